//--- rtl/sacfs_pkg.sv
/*
  Constants, field layouts and carrier types for the sub-audio, code-squelch,
  level-adjust, gain-loop and fast FSK signalling block.
  Assumes a single 100 MHz system clock and an active-low asynchronous reset.
*/
package sacfs_pkg;

  localparam int unsigned SACFS_CLK_HZ = 100_000_000;
  localparam int unsigned SACFS_BAUD = 1200;
  // Bit time rounds down to whole cycles.
  localparam int unsigned SACFS_BIT_CYCLES = SACFS_CLK_HZ / SACFS_BAUD;
  localparam int unsigned SACFS_F_ONE_HZ = 1200;
  localparam int unsigned SACFS_F_ZERO_HZ = 1800;
  localparam int unsigned SACFS_F_TURNOFF_HZ = 134;
  localparam logic [31:0] SACFS_INC_ONE =
    32'((64'(SACFS_F_ONE_HZ) << 32) / 64'(SACFS_CLK_HZ));
  localparam logic [31:0] SACFS_INC_ZERO =
    32'((64'(SACFS_F_ZERO_HZ) << 32) / 64'(SACFS_CLK_HZ));
  localparam logic [31:0] SACFS_INC_TURNOFF =
    32'((64'(SACFS_F_TURNOFF_HZ) << 32) / 64'(SACFS_CLK_HZ));

  localparam int unsigned SACFS_FSK_ENABLE_BIT = 8;

  localparam logic [7:0] SACFS_DCS_NONE = 8'h00;
  localparam logic [7:0] SACFS_DCS_USER = 8'h54;
  localparam logic [7:0] SACFS_DCS_INV_OFS = 8'h64;
  localparam logic [7:0] SACFS_DCS_INV_MAX = 8'hB8;
  localparam logic [7:0] SACFS_TONE_NONE = 8'hC8;
  localparam logic [7:0] SACFS_TONE_USER = 8'hFC;
  localparam logic [7:0] SACFS_TONE_PHASE = 8'hFD;
  localparam logic [7:0] SACFS_TONE_TURNOFF = 8'hFE;
  localparam logic [7:0] SACFS_TONE_INVALID = 8'hFF;

  // Analogue control register level fields, 4 bits each, 8 is unity.
  localparam int unsigned SACFS_LVL_VOICE_LSB = 0;
  localparam int unsigned SACFS_LVL_INBAND_LSB = 4;
  localparam int unsigned SACFS_LVL_SUB_LSB = 8;
  localparam int unsigned SACFS_LVL_SHIFT = 3;

  // Gain loop parameter layout.
  localparam int unsigned SACFS_AGC_MAXG_LSB = 4;
  localparam int unsigned SACFS_AGC_DECAY_SHIFT = 8;
  localparam logic [3:0] SACFS_AGC_GAIN_RESET = 4'h0;

  localparam logic [7:0] SACFS_STATUS_RESET = 8'hFF;

  typedef enum logic [3:0] {
    SACFS_SUB_OFF = 4'b0001,
    SACFS_SUB_DCS = 4'b0010,
    SACFS_SUB_TONE = 4'b0100,
    SACFS_SUB_TURNOFF = 4'b1000
  } sacfs_sub_kind_t;

  typedef struct packed {
    sacfs_sub_kind_t kind;
    logic [6:0] index;
    logic inverted;
    logic user;
  } sacfs_sub_sel_t;

  typedef struct packed {
    logic signed [15:0] voice;
    logic signed [15:0] inband;
    logic signed [15:0] sub;
  } sacfs_audio_t;

  typedef struct packed {
    logic [7:0] threshold;
    logic [3:0] bandwidth;
  } sacfs_det_cfg_t;

  typedef enum logic [1:0] {
    SACFS_FSK_IDLE = 2'b01,
    SACFS_FSK_SEND = 2'b10
  } sacfs_fsk_state_t;

endpackage

//--- rtl/sacfs_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock; full and empty come straight from the occupancy count.
*/
`timescale 1ns/1ps
module sacfs_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign o_in_ready = (count_r != (AW+1)'(DEPTH));
  assign o_out_valid = (count_r != '0);
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem_r[rd_ptr_r];

  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem_r[wr_ptr_r] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

//--- rtl/sacfs_core.sv
/*
  Analogue signalling core: microphone gain loop, level adjustment, sub-audio
  code mapping in both directions, phase-change handling and the fast FSK
  modulator fed through a small FIFO.
  Assumes every input comes from logic on i_clk_sys; the host-side register
  values arrive as plain ports already decoded by the control-port logic.
*/
`timescale 1ns/1ps
module sacfs_core
  import sacfs_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = SACFS_BIT_CYCLES,
  parameter int unsigned FIFO_DEPTH = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic [15:0] i_mode_control_reg,
  input wire logic [7:0] i_analogue_mode_reg,
  input wire logic [15:0] i_analogue_control_reg,
  input wire logic i_analogue_control_wr,
  input wire logic [7:0] i_subaudio_config_param,
  input wire logic [7:0] i_agc_threshold_param,
  input wire logic [7:0] i_agc_max_gain_decay_param,
  input wire logic [11:0] i_subaudio_detector_setup_param,
  input wire logic i_agc_enable,
  input wire logic [3:0] i_host_in1_gain,
  input wire logic i_mic_stb,
  input wire logic [7:0] i_mic_level,
  input wire logic i_subaudio_tx_en,
  input wire logic i_tail_elim,
  input wire logic i_tail_invert_mode,
  input wire sacfs_audio_t i_tx_audio,
  input wire sacfs_audio_t i_rx_audio,
  input wire logic i_rx_det_stb,
  input wire logic i_rx_det_is_dcs,
  input wire logic [6:0] i_rx_det_index,
  input wire logic i_rx_det_inverted,
  input wire logic i_rx_phase_rev,
  input wire logic i_fsk_data_valid,
  output logic o_fsk_data_ready,
  input wire logic [7:0] i_fsk_data,
  output logic [3:0] o_in1_gain,
  output sacfs_audio_t o_tx_audio,
  output sacfs_audio_t o_rx_audio,
  output sacfs_sub_sel_t o_tx_sub_sel,
  output logic [31:0] o_sub_phase_inc,
  output logic o_tone_phase_flip,
  output logic o_mod_invert,
  output sacfs_det_cfg_t o_det_cfg,
  output logic o_phase_det_active,
  output logic [7:0] o_aux_status_code,
  output logic o_aux_status_stb,
  output logic o_fsk_active,
  output logic o_fsk_bit,
  output logic [7:0] o_fsk_phase
);

  // Level scaling: 4-bit gain, 8 is unity, result saturates to 16 bits.
  function automatic logic signed [15:0] scale(input logic signed [15:0] s,
                                               input logic [3:0] g);
    logic signed [20:0] p;
    logic signed [20:0] q;
    p = s * $signed({1'b0, g});
    q = p >>> SACFS_LVL_SHIFT;
    if (q > 21'sd32767) begin
      scale = 16'sh7FFF;
    end else if (q < -21'sd32768) begin
      scale = -16'sh8000;
    end else begin
      scale = q[15:0];
    end
  endfunction

  // Map an 8-bit register code onto the kind of sub-audio signal.
  function automatic sacfs_sub_sel_t decode(input logic [7:0] c);
    decode = '{kind: SACFS_SUB_OFF, index: 7'h00, inverted: 1'b0, user: 1'b0};
    if (c >= 8'h01 && c <= SACFS_DCS_USER) begin
      decode.kind = SACFS_SUB_DCS;
      decode.index = c[6:0];
      decode.user = (c == SACFS_DCS_USER);
    end else if (c > SACFS_DCS_INV_OFS && c <= SACFS_DCS_INV_MAX) begin
      decode.kind = SACFS_SUB_DCS;
      decode.index = 7'(c - SACFS_DCS_INV_OFS);
      decode.inverted = 1'b1;
      decode.user = (c == SACFS_DCS_INV_MAX);
    end else if (c > SACFS_TONE_NONE && c <= SACFS_TONE_USER) begin
      decode.kind = SACFS_SUB_TONE;
      decode.index = 7'(c - SACFS_TONE_NONE);
      decode.user = (c == SACFS_TONE_USER);
    end else if (c == SACFS_TONE_TURNOFF) begin
      decode.kind = SACFS_SUB_TURNOFF;
    end
  endfunction

  logic [3:0] gain_r;
  logic [15:0] decay_cnt_r;
  logic [15:0] decay_limit;
  logic [3:0] max_gain;
  sacfs_sub_sel_t code_sel;
  sacfs_sub_sel_t sub_sel_r;
  logic tail_r;
  logic tone_running;
  logic flip_r;
  logic invert_r;
  logic [7:0] status_r;
  logic status_stb_r;
  sacfs_audio_t tx_r;
  sacfs_audio_t rx_r;
  sacfs_det_cfg_t det_r;
  sacfs_fsk_state_t fsk_state_r;
  logic fsk_en;
  logic [$clog2(BIT_CYCLES)-1:0] bit_cnt_r;
  logic bit_end;
  logic [7:0] shift_r;
  logic [2:0] bits_left_r;
  logic have_byte_r;
  logic cur_bit_r;
  logic [31:0] acc_r;
  logic [31:0] sub_inc_r;
  logic fifo_valid;
  logic fifo_pop;
  logic [7:0] fifo_data;

  assign max_gain = i_agc_max_gain_decay_param[7:SACFS_AGC_MAXG_LSB];
  assign decay_limit = {4'h0, i_agc_max_gain_decay_param[3:0], 8'h00};

  // The loop only moves on mic samples, so gain steps track the speech envelope.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      gain_r <= SACFS_AGC_GAIN_RESET;
      decay_cnt_r <= 16'h0000;
    end else if (!i_agc_enable) begin
      gain_r <= i_host_in1_gain;
      decay_cnt_r <= 16'h0000;
    end else if (i_mic_stb) begin
      if (gain_r > max_gain) begin
        gain_r <= max_gain;
      end else if (i_mic_level > i_agc_threshold_param) begin
        decay_cnt_r <= 16'h0000;
        if (gain_r != 4'h0) begin
          gain_r <= gain_r - 4'h1;
        end
      end else if (decay_cnt_r >= decay_limit) begin
        decay_cnt_r <= 16'h0000;
        if (gain_r < max_gain) begin
          gain_r <= gain_r + 4'h1;
        end
      end else begin
        decay_cnt_r <= decay_cnt_r + 16'h0001;
      end
    end
  end
  // Host gain is ignored while the loop is on, so its writes cannot fight it.
  assign o_in1_gain = gain_r;

  // Both paths run every cycle, so detection never stalls voice.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_r <= '0;
      rx_r <= '0;
    end else begin
      tx_r.voice <= scale(i_tx_audio.voice, i_analogue_control_reg[SACFS_LVL_VOICE_LSB+:4]);
      tx_r.inband <= scale(i_tx_audio.inband, i_analogue_control_reg[SACFS_LVL_INBAND_LSB+:4]);
      tx_r.sub <= scale(i_tx_audio.sub, i_analogue_control_reg[SACFS_LVL_SUB_LSB+:4]);
      rx_r.voice <= scale(i_rx_audio.voice, i_analogue_control_reg[SACFS_LVL_VOICE_LSB+:4]);
      rx_r.inband <= scale(i_rx_audio.inband, i_analogue_control_reg[SACFS_LVL_INBAND_LSB+:4]);
      rx_r.sub <= scale(i_rx_audio.sub, i_analogue_control_reg[SACFS_LVL_SUB_LSB+:4]);
    end
  end
  assign o_tx_audio = tx_r;
  assign o_rx_audio = rx_r;

  assign code_sel = decode(i_analogue_mode_reg);
  assign tone_running = i_subaudio_tx_en && (sub_sel_r.kind == SACFS_SUB_TONE);

  // Transmit selection; outside invert mode the tail request swaps a code for the turn-off tone.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      sub_sel_r <= '{kind: SACFS_SUB_OFF, index: 7'h00, inverted: 1'b0, user: 1'b0};
      sub_inc_r <= 32'h0000_0000;
      tail_r <= 1'b0;
    end else begin
      tail_r <= i_tail_elim;
      if (i_tail_elim && !i_tail_invert_mode && code_sel.kind == SACFS_SUB_DCS) begin
        sub_sel_r <= '{kind: SACFS_SUB_TURNOFF, index: 7'h00, inverted: 1'b0, user: 1'b0};
        sub_inc_r <= SACFS_INC_TURNOFF;
      end else begin
        sub_sel_r <= code_sel;
        sub_inc_r <= (code_sel.kind == SACFS_SUB_TURNOFF) ? SACFS_INC_TURNOFF : 32'h0000_0000;
      end
    end
  end
  assign o_tx_sub_sel = sub_sel_r;
  assign o_sub_phase_inc = sub_inc_r;

  // Tone phase flips on a control write, or on tail start in phase mode.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      flip_r <= 1'b0;
      invert_r <= 1'b0;
    end else begin
      if (tone_running && (i_analogue_control_wr ||
          (i_tail_elim && !tail_r && !i_tail_invert_mode))) begin
        flip_r <= ~flip_r;
      end
      invert_r <= i_tail_elim && i_tail_invert_mode;
    end
  end
  assign o_tone_phase_flip = flip_r;
  assign o_mod_invert = invert_r;

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      det_r <= '0;
    end else begin
      det_r <= i_subaudio_detector_setup_param;
    end
  end
  assign o_det_cfg = det_r;
  assign o_phase_det_active = i_subaudio_config_param[2];

  // Receive status; an enabled phase reversal outranks a simultaneous tone report.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      status_r <= SACFS_STATUS_RESET;
      status_stb_r <= 1'b0;
    end else begin
      status_stb_r <= 1'b0;
      if (i_rx_phase_rev && i_subaudio_config_param[2]) begin
        status_r <= SACFS_TONE_PHASE;
        status_stb_r <= 1'b1;
      end else if (i_rx_det_stb) begin
        status_stb_r <= 1'b1;
        if (i_rx_det_is_dcs) begin
          if (i_rx_det_index > SACFS_DCS_USER[6:0]) begin
            status_r <= SACFS_TONE_INVALID;
          end else begin
            status_r <= {1'b0, i_rx_det_index} +
                        (i_rx_det_inverted ? SACFS_DCS_INV_OFS : 8'h00);
          end
        end else if (i_rx_det_index > 7'(SACFS_TONE_USER - SACFS_TONE_NONE)) begin
          status_r <= SACFS_TONE_INVALID;
        end else begin
          status_r <= SACFS_TONE_NONE + {1'b0, i_rx_det_index};
        end
      end
    end
  end
  assign o_aux_status_code = status_r;
  assign o_aux_status_stb = status_stb_r;

  assign fsk_en = i_mode_control_reg[SACFS_FSK_ENABLE_BIT];
  assign bit_end = (bit_cnt_r == ($clog2(BIT_CYCLES))'(BIT_CYCLES - 1));
  assign fifo_pop = bit_end && (bits_left_r == 3'h0) && (fsk_state_r == SACFS_FSK_SEND);

  sacfs_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_in_valid(i_fsk_data_valid),
    .o_in_ready(o_fsk_data_ready),
    .i_in_data(i_fsk_data),
    .o_out_valid(fifo_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_data)
  );

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      fsk_state_r <= SACFS_FSK_IDLE;
    end else begin
      unique case (fsk_state_r)
        SACFS_FSK_IDLE: begin
          if (fsk_en) begin
            fsk_state_r <= SACFS_FSK_SEND;
          end
        end
        SACFS_FSK_SEND: begin
          if (!fsk_en) begin
            fsk_state_r <= SACFS_FSK_IDLE;
          end
        end
      endcase
    end
  end

  // Baud divider and serialiser; an empty FIFO sends ones as idle fill.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      bit_cnt_r <= '0;
      shift_r <= 8'h00;
      bits_left_r <= 3'h0;
      have_byte_r <= 1'b0;
      cur_bit_r <= 1'b1;
    end else if (fsk_state_r != SACFS_FSK_SEND) begin
      bit_cnt_r <= '0;
      bits_left_r <= 3'h0;
      have_byte_r <= 1'b0;
      cur_bit_r <= 1'b1;
    end else if (bit_end) begin
      bit_cnt_r <= '0;
      if (bits_left_r != 3'h0) begin
        cur_bit_r <= shift_r[7];
        shift_r <= {shift_r[6:0], 1'b0};
        bits_left_r <= bits_left_r - 3'h1;
      end else if (fifo_valid) begin
        cur_bit_r <= fifo_data[7];
        shift_r <= {fifo_data[6:0], 1'b0};
        bits_left_r <= 3'h7;
        have_byte_r <= 1'b1;
      end else begin
        cur_bit_r <= 1'b1;
        have_byte_r <= 1'b0;
      end
    end else begin
      bit_cnt_r <= bit_cnt_r + 1'b1;
    end
  end

  // The accumulator is never reset at bit edges, only its step changes.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      acc_r <= 32'h0000_0000;
    end else if (fsk_state_r == SACFS_FSK_SEND) begin
      acc_r <= acc_r + (cur_bit_r ? SACFS_INC_ONE : SACFS_INC_ZERO);
    end
  end

  assign o_fsk_active = (fsk_state_r == SACFS_FSK_SEND) && have_byte_r;
  assign o_fsk_bit = cur_bit_r;
  assign o_fsk_phase = acc_r[31:24];

endmodule

//--- tb/sacfs_core_properties.sv
/*
  Port checker for the signalling core: status codes, phase flips, gain loop and modem state.
  Assumes it is bound into sacfs_core and shares its single clock and reset.
*/
`timescale 1ns/1ps
module sacfs_core_properties
  import sacfs_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic [15:0] i_mode_control_reg,
  input wire logic [7:0] i_analogue_mode_reg,
  input wire logic [15:0] i_analogue_control_reg,
  input wire logic i_analogue_control_wr,
  input wire logic [7:0] i_subaudio_config_param,
  input wire logic [7:0] i_agc_threshold_param,
  input wire logic [7:0] i_agc_max_gain_decay_param,
  input wire logic i_agc_enable,
  input wire logic [3:0] i_host_in1_gain,
  input wire logic i_mic_stb,
  input wire logic [7:0] i_mic_level,
  input wire logic i_subaudio_tx_en,
  input wire logic i_tail_elim,
  input wire logic i_tail_invert_mode,
  input wire sacfs_audio_t i_tx_audio,
  input wire logic i_rx_det_stb,
  input wire logic i_rx_det_is_dcs,
  input wire logic [6:0] i_rx_det_index,
  input wire logic i_rx_det_inverted,
  input wire logic i_rx_phase_rev,
  input wire logic [3:0] o_in1_gain,
  input wire sacfs_audio_t o_tx_audio,
  input wire sacfs_sub_sel_t o_tx_sub_sel,
  input wire logic [31:0] o_sub_phase_inc,
  input wire logic o_tone_phase_flip,
  input wire logic o_phase_det_active,
  input wire logic [7:0] o_aux_status_code,
  input wire logic o_aux_status_stb,
  input wire logic o_fsk_active
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  logic pe;
  // A phase report outranks a detector report in the same cycle.
  assign pe = i_rx_phase_rev && i_subaudio_config_param[2];
  AST_PHASE_DET_EN: assert property (o_phase_det_active == i_subaudio_config_param[2])
    else $error("phase detector enable mismatch");
  AST_PHASE_IGNORED: assert property (
    i_rx_phase_rev && !i_subaudio_config_param[2] && !i_rx_det_stb |=> !o_aux_status_stb)
    else $error("disabled phase report produced a strobe");
  AST_PHASE_CODE: assert property (
    pe |=> o_aux_status_stb && o_aux_status_code == 8'hFD)
    else $error("phase reversal not reported");
  AST_RX_DCS: assert property (
    i_rx_det_stb && !pe && i_rx_det_is_dcs && i_rx_det_index <= 7'h54 |=>
    o_aux_status_code == {1'b0, $past(i_rx_det_index)} + ($past(i_rx_det_inverted) ? 8'h64 : 8'h00))
    else $error("code squelch status wrong");
  AST_RX_TONE: assert property (
    i_rx_det_stb && !pe && !i_rx_det_is_dcs && i_rx_det_index <= 7'h34 |=>
    o_aux_status_code == 8'hC8 + {1'b0, $past(i_rx_det_index)})
    else $error("tone status wrong");
  AST_FLIP_ON_WRITE: assert property (
    i_analogue_control_wr && i_subaudio_tx_en && o_tx_sub_sel.kind == SACFS_SUB_TONE |=>
    o_tone_phase_flip != $past(o_tone_phase_flip))
    else $error("control write did not flip tone phase");
  AST_TAIL_TURNOFF: assert property (
    i_tail_elim && !i_tail_invert_mode && i_analogue_mode_reg inside {[8'h01:8'h54]} |=>
    o_tx_sub_sel.kind == SACFS_SUB_TURNOFF && o_sub_phase_inc == SACFS_INC_TURNOFF)
    else $error("turn-off tone not selected");
  AST_GAIN_HOST: assert property (
    !i_agc_enable |=> o_in1_gain == $past(i_host_in1_gain))
    else $error("host gain not followed");
  AST_GAIN_DOWN: assert property (
    i_agc_enable && i_mic_stb && i_mic_level > i_agc_threshold_param && o_in1_gain != 4'h0 &&
    o_in1_gain <= i_agc_max_gain_decay_param[7:4] |=> o_in1_gain == $past(o_in1_gain) - 4'h1)
    else $error("gain not reduced above threshold");
  AST_VOICE_UNITY: assert property (
    i_analogue_control_reg[3:0] == 4'h8 |=> o_tx_audio.voice == $past(i_tx_audio.voice))
    else $error("unity voice level altered the sample");
  AST_FSK_OFF: assert property (!i_mode_control_reg[8] |=> !o_fsk_active)
    else $error("modem active with mode bit clear");
  COV_PHASE: cover property (pe ##1 o_aux_status_stb);
  COV_FSK: cover property ($rose(o_fsk_active));
  COV_FLIP: cover property ($changed(o_tone_phase_flip));
endmodule
bind sacfs_core sacfs_core_properties u_props (.*);

//--- tb/sacfs_host_model.sv
/*
  Host byte source for the modem data port.
  Assumes a ready that settles within 1 ns of a rising edge, where it is sampled, and holds to the next edge.
*/
`timescale 1ns/1ps
module sacfs_host_model (
  input wire logic i_clk_sys,
  input wire logic i_ready,
  output logic o_valid,
  output logic [7:0] o_data
);
  initial begin
    o_valid = 1'b0;
    o_data = 8'h00;
  end
  // Gives up after eight edges so a full buffer cannot hang the caller.
  task automatic push(input logic [7:0] b, output logic ok);
    int n;
    logic r;
    @(posedge i_clk_sys);
    o_valid <= 1'b1;
    o_data <= b;
    ok = 1'b0;
    for (n = 0; n < 8 && !ok; n++) begin
      #1;
      r = i_ready;
      @(posedge i_clk_sys);
      ok = r;
    end
    o_valid <= 1'b0;
    o_data <= ~b;
  endtask
endmodule

//--- tb/sacfs_core_tb_top.sv
/*
  Self-checking bench for the signalling core with a short bit time.
  Assumes the host byte source model and the bound port checker.
*/
`timescale 1ns/1ps
module sacfs_core_tb_top
  import sacfs_pkg::*;
();
  localparam int unsigned BC = 40;
  logic i_clk_sys, i_resetn, i_analogue_control_wr, i_agc_enable, i_mic_stb, i_subaudio_tx_en;
  logic i_tail_elim, i_tail_invert_mode, i_rx_det_stb, i_rx_det_is_dcs, i_rx_det_inverted;
  logic i_rx_phase_rev, i_fsk_data_valid, o_fsk_data_ready, o_tone_phase_flip, o_mod_invert;
  logic o_phase_det_active, o_aux_status_stb, o_fsk_active, o_fsk_bit, ok;
  logic [15:0] i_mode_control_reg, i_analogue_control_reg;
  logic [11:0] i_subaudio_detector_setup_param;
  logic [7:0] i_analogue_mode_reg, i_subaudio_config_param, i_agc_threshold_param;
  logic [7:0] i_agc_max_gain_decay_param, i_mic_level, i_fsk_data, o_aux_status_code, o_fsk_phase;
  logic [6:0] i_rx_det_index;
  logic [3:0] i_host_in1_gain, o_in1_gain;
  logic [31:0] o_sub_phase_inc;
  sacfs_audio_t i_tx_audio, i_rx_audio, o_tx_audio, o_rx_audio;
  sacfs_sub_sel_t o_tx_sub_sel;
  sacfs_det_cfg_t o_det_cfg;
  int failures, checks_done, i, n;
  int cyc = 0;
  logic [7:0] tc [9] = '{8'h00, 8'h05, 8'h69, 8'h54, 8'hB8, 8'hC8, 8'hD2, 8'hFC, 8'hFE};
  logic [5:0] te [9] = '{6'h04, 6'h08, 6'h0A, 6'h09, 6'h0B, 6'h04, 6'h10, 6'h11, 6'h20};
  logic [7:0] fb [5] = '{8'hA5, 8'h3C, 8'hF0, 8'h81, 8'h55};
  logic [31:0] st = 32'hA53CF081;

  sacfs_core #(.BIT_CYCLES(BC), .FIFO_DEPTH(4)) DUT (.*);
  sacfs_host_model u_host (.i_clk_sys(i_clk_sys), .i_ready(o_fsk_data_ready),
    .o_valid(i_fsk_data_valid), .o_data(i_fsk_data));

  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  task automatic chk(input logic c, input string m);
    checks_done++;
    if (c !== 1'b1) begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  task automatic nx();
    @(posedge i_clk_sys);
    #1;
  endtask

  task automatic gs(input logic [7:0] lv, input logic [3:0] g);
    @(posedge i_clk_sys);
    i_agc_enable <= 1'b1;
    i_mic_stb <= 1'b1;
    i_mic_level <= lv;
    @(posedge i_clk_sys);
    i_mic_stb <= 1'b0;
    #1;
    chk(o_in1_gain === g, "gain loop");
  endtask

  task automatic fl(input logic w, input logic t, input logic e);
    logic f;
    f = o_tone_phase_flip;
    @(posedge i_clk_sys);
    i_analogue_control_wr <= w;
    i_tail_elim <= t;
    i_subaudio_tx_en <= e;
    @(posedge i_clk_sys);
    i_analogue_control_wr <= 1'b0;
    i_tail_elim <= 1'b0;
    #1;
    chk(o_tone_phase_flip === (f ^ (e & (w | t))), "phase flip");
  endtask

  task automatic rx(input logic s, input logic d, input logic p, input logic e,
      input logic [6:0] x, input logic v, input logic [7:0] c);
    @(posedge i_clk_sys);
    {i_rx_det_stb, i_rx_det_is_dcs, i_rx_phase_rev, i_rx_det_inverted} <= {s, d, p, v};
    i_subaudio_config_param <= {5'h00, e, 2'h0};
    i_rx_det_index <= x;
    @(posedge i_clk_sys);
    {i_rx_det_stb, i_rx_phase_rev} <= 2'h0;
    #1;
    chk(o_aux_status_stb === (s | (p & e)) && o_aux_status_code === c, "rx status");
  endtask

  task end_of_test;
    $display("checks_done %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      failures++;
      end_of_test();
    end
  end

  initial begin
    {i_resetn, i_analogue_control_wr, i_agc_enable, i_mic_stb, i_subaudio_tx_en} = '0;
    {i_tail_elim, i_tail_invert_mode, i_rx_det_stb, i_rx_det_is_dcs, i_rx_det_inverted} = '0;
    {i_rx_phase_rev, i_mode_control_reg, i_analogue_control_reg} = '0;
    {i_subaudio_detector_setup_param, i_analogue_mode_reg, i_subaudio_config_param} = '0;
    {i_agc_threshold_param, i_agc_max_gain_decay_param, i_mic_level} = '0;
    {i_rx_det_index, i_host_in1_gain, i_tx_audio, i_rx_audio} = '0;
    failures = 0;
    checks_done = 0;
    repeat (8) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    @(posedge i_clk_sys);
    i_analogue_control_reg <= 16'h0F48;
    i_tx_audio <= {16'h03E8, 16'h03E8, 16'h4E20};
    i_rx_audio <= {16'hFC18, 16'h03E8, 16'hB1E0};
    i_subaudio_detector_setup_param <= 12'hA53;
    i_subaudio_config_param <= 8'h04;
    i_host_in1_gain <= 4'h5;
    i_agc_threshold_param <= 8'h40;
    i_agc_max_gain_decay_param <= 8'h60;
    nx();
    chk(o_tx_audio === {16'h03E8, 16'h01F4, 16'h7FFF}, "tx levels");
    chk(o_rx_audio === {16'hFC18, 16'h01F4, 16'h8000}, "rx levels");
    chk(o_det_cfg === 12'hA53, "detector setup");
    chk(o_phase_det_active === 1'b1, "phase enable");
    chk(o_in1_gain === 4'h5, "host gain");
    $display("levels test done");
    gs(8'h41, 4'h4);
    gs(8'h40, 4'h5);
    gs(8'h10, 4'h6);
    gs(8'h10, 4'h6);
    @(posedge i_clk_sys);
    i_agc_enable <= 1'b0;
    nx();
    chk(o_in1_gain === 4'h5, "gain loop off");
    $display("gain test done");
    for (i = 0; i < 9; i++) begin
      @(posedge i_clk_sys);
      i_analogue_mode_reg <= tc[i];
      nx();
      ok = {o_tx_sub_sel.kind, o_tx_sub_sel.inverted, o_tx_sub_sel.user} === te[i];
      ok = ok && o_sub_phase_inc === (te[i][5] ? SACFS_INC_TURNOFF : 32'h0);
      chk(ok, "tx code");
    end
    @(posedge i_clk_sys);
    i_analogue_mode_reg <= 8'h05;
    i_tail_elim <= 1'b1;
    nx();
    ok = o_tx_sub_sel.kind === SACFS_SUB_TURNOFF && o_sub_phase_inc === SACFS_INC_TURNOFF;
    chk(ok, "turn-off tone");
    @(posedge i_clk_sys);
    i_tail_invert_mode <= 1'b1;
    nx();
    chk(o_mod_invert === 1'b1, "tail invert");
    @(posedge i_clk_sys);
    {i_tail_elim, i_tail_invert_mode} <= 2'h0;
    i_analogue_mode_reg <= 8'hD2;
    nx();
    fl(1'b1, 1'b0, 1'b1);
    fl(1'b0, 1'b1, 1'b1);
    fl(1'b1, 1'b0, 1'b0);
    $display("tx code test done");
    rx(1'b1, 1'b1, 1'b0, 1'b0, 7'h05, 1'b0, 8'h05);
    rx(1'b1, 1'b1, 1'b0, 1'b0, 7'h05, 1'b1, 8'h69);
    rx(1'b1, 1'b1, 1'b0, 1'b0, 7'h54, 1'b1, 8'hB8);
    rx(1'b1, 1'b1, 1'b0, 1'b0, 7'h55, 1'b0, 8'hFF);
    rx(1'b1, 1'b0, 1'b0, 1'b0, 7'h01, 1'b0, 8'hC9);
    rx(1'b1, 1'b0, 1'b0, 1'b0, 7'h34, 1'b0, 8'hFC);
    rx(1'b1, 1'b0, 1'b0, 1'b0, 7'h35, 1'b0, 8'hFF);
    rx(1'b1, 1'b0, 1'b1, 1'b1, 7'h0A, 1'b0, 8'hFD);
    rx(1'b0, 1'b0, 1'b1, 1'b0, 7'h0A, 1'b0, 8'hFD);
    $display("rx status test done");
    // The modem stays off while the buffer fills, so the fifth byte must be refused.
    @(posedge i_clk_sys);
    i_subaudio_tx_en <= 1'b1;
    for (i = 0; i < 5; i++) begin
      u_host.push(fb[i], ok);
      chk(ok === (i < 4), "buffer accept");
    end
    #1;
    chk(o_fsk_data_ready === 1'b0, "buffer full");
    @(posedge i_clk_sys);
    i_mode_control_reg <= 16'h0100;
    n = 0;
    while (o_fsk_active !== 1'b1 && n < 200) begin
      nx();
      n++;
    end
    repeat (BC / 2 - 1) @(posedge i_clk_sys);
    nx();
    for (i = 0; i < 32; i++) begin
      ok = o_fsk_bit === st[31 - i] && o_tx_sub_sel.kind === SACFS_SUB_TONE;
      chk(ok, "bit");
      repeat (BC - 1) @(posedge i_clk_sys);
      nx();
    end
    ok = o_fsk_active === 1'b0 && o_fsk_bit === 1'b1 && o_fsk_data_ready === 1'b1;
    chk(ok, "modem idle");
    ok = o_fsk_phase === 8'((32'd620 * SACFS_INC_ONE + 32'd720 * SACFS_INC_ZERO) >> 24);
    chk(ok, "carrier phase");
    u_host.push(8'h55, ok);
    chk(ok, "modem accept");
    n = 0;
    while (o_fsk_active !== 1'b1 && n < 200) begin
      nx();
      n++;
    end
    chk(o_fsk_active === 1'b1, "modem restart");
    @(posedge i_clk_sys);
    i_mode_control_reg <= 16'h0000;
    nx();
    chk(o_fsk_active === 1'b0, "modem off");
    $display("modem test done");
    end_of_test();
  end
endmodule
